// ### src/sbg_baud_gen.sv
// Three baud rate generators with their compare and prescaler mode registers.
// Assumes a single-cycle register master on clk_i; the serial ports sample the
// generated clocks and match pulses synchronously on the same clock.
// Changing compare or prescale takes effect at once; idle the serial ports first.
//
// Added by the designer: the strobed register port.
`default_nettype none

module sbg_baud_gen #(
  parameter int NUM_UNITS = 3
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire sbg_pkg::sbg_req_t req_i,
  output logic [sbg_pkg::SBG_DW-1:0] rdata_o,
  output logic [NUM_UNITS-1:0] baud_clk_o,
  output logic [NUM_UNITS-1:0] match_o
);
  import sbg_pkg::*;

  // The address table holds exactly three generators
  if (NUM_UNITS != SBG_UNITS)
  begin : g_bad_units
    $error("sbg_baud_gen: NUM_UNITS must equal SBG_UNITS");
  end
  // Byte registers with the count select below the enable bit
  if (SBG_DW != 8)
  begin : g_bad_width
    $error("sbg_baud_gen: SBG_DW must be 8");
  end
  if ((SBG_MODE_SEL_LSB + SBG_MODE_SEL_W > SBG_MODE_EN_BIT) || (SBG_MODE_EN_BIT >= SBG_DW))
  begin : g_bad_fields
    $error("sbg_baud_gen: mode register fields do not fit");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-generator registers and timer

  // Per-unit read values, merged into one registered read port below
  logic [NUM_UNITS-1:0][7:0] rd_val;
  logic [NUM_UNITS-1:0] rd_hit;

  for (genvar u = 0; u < NUM_UNITS; u++)
  begin : g_unit
    logic [7:0] cmp_r, cmp_nxt;
    sbg_cfg_t cfg_r, cfg_nxt;
    logic [4:0] pre_r, pre_nxt;
    logic [7:0] tmr_r, tmr_nxt;
    logic clk_r, clk_nxt;
    logic match_r, match_nxt;
    logic hit_cmp, hit_mode;
    logic wr_cmp, wr_mode;
    logic [7:0] mode_val, mode_new;
    logic [2:0] k;
    logic [4:0] pre_last;
    logic tick;
    logic halt;

    // Exact address match only; neighbouring addresses do not alias
    assign hit_cmp = (req_i.addr == SBG_ADDR_CMP[u]);
    assign hit_mode = (req_i.addr == SBG_ADDR_MODE[u]);
    assign wr_cmp = req_i.wr && hit_cmp;
    assign wr_mode = req_i.wr && hit_mode;
    assign mode_val = {cfg_r.en, 4'h0, cfg_r.sel};
    assign rd_hit[u] = req_i.rd && (hit_cmp || hit_mode);
    assign rd_val[u] = hit_cmp ? cmp_r : mode_val;
    // A stopped generator and a compare write both restart from the cleared state
    assign halt = !cfg_r.en || wr_cmp;

    always_comb
    begin
      // Masked write merges a single bit or a whole byte
      mode_new = (mode_val & ~req_i.wmask) | (req_i.wdata & req_i.wmask);
      cmp_nxt = cmp_r;
      cfg_nxt = cfg_r;
      if (wr_cmp)
      begin
        cmp_nxt = (cmp_r & ~req_i.wmask) | (req_i.wdata & req_i.wmask);
      end
      // Mode bits 6..3 are not stored and read back as zero
      if (wr_mode)
      begin
        cfg_nxt.en = mode_new[SBG_MODE_EN_BIT];
        cfg_nxt.sel = mode_new[SBG_MODE_SEL_LSB +: SBG_MODE_SEL_W];
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        cmp_r <= SBG_CMP_RST;
        cfg_r.en <= SBG_MODE_RST[SBG_MODE_EN_BIT];
        cfg_r.sel <= SBG_MODE_RST[SBG_MODE_SEL_LSB +: SBG_MODE_SEL_W];
      end
      else
      begin
        cmp_r <= cmp_nxt;
        cfg_r <= cfg_nxt;
      end
    end

    // Prescaler: a counted divide by 2^(k+1), so a restart lands exactly on count zero
    always_comb
    begin
      case (cfg_r.sel)
        3'h0: k = 3'h0;
        3'h1: k = 3'h1;
        3'h2: k = 3'h2;
        3'h3: k = 3'h3;
        default: k = SBG_PRE_MAX_K;
      endcase
      // The timer moves only on the last prescaler count
      pre_last = 5'((6'h02 << k) - 6'h01);
      tick = (pre_r == pre_last);
      pre_nxt = tick ? 5'h00 : 5'(pre_r + 5'h01);
      if (halt)
      begin
        pre_nxt = 5'h00;
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        pre_r <= 5'h00;
      end
      else
      begin
        pre_r <= pre_nxt;
      end
    end

    // Timer: match_o and baud_clk_o change on one edge, so a serial port may use either
    always_comb
    begin
      tmr_nxt = tmr_r;
      clk_nxt = clk_r;
      match_nxt = 1'b0;
      if (tick)
      begin
        // Last count is compare-1 modulo 256, so zero gives 256 counts
        if (tmr_r == 8'(cmp_r - 8'h01))
        begin
          tmr_nxt = 8'h00;
          match_nxt = 1'b1;
          clk_nxt = ~clk_r;
        end
        else
        begin
          tmr_nxt = 8'(tmr_r + 8'h01);
        end
      end
      // A match suppressed by a compare write leaves the clock level alone too, so the two never drift apart
      if (halt)
      begin
        tmr_nxt = 8'h00;
        match_nxt = 1'b0;
        clk_nxt = clk_r;
      end
      // Parking low means a restart after a stop always begins with a rising edge
      if (!cfg_r.en)
      begin
        clk_nxt = 1'b0;
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        tmr_r <= 8'h00;
        clk_r <= 1'b0;
        match_r <= 1'b0;
      end
      else
      begin
        tmr_r <= tmr_nxt;
        clk_r <= clk_nxt;
        match_r <= match_nxt;
      end
    end

    assign baud_clk_o[u] = clk_r;
    assign match_o[u] = match_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads return zero

  logic [SBG_DW-1:0] rdata_r, rdata_nxt;

  always_comb
  begin
    // Only one address can hit, so the OR merge needs no priority
    rdata_nxt = 8'h00;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      if (rd_hit[i])
      begin
        rdata_nxt = rdata_nxt | rd_val[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule : sbg_baud_gen

`default_nettype wire

// ### src/sbg_dummy_unused.sv
`default_nettype none
`default_nettype wire

// ### src/sbg_pkg.sv
// Constants, register map and carrier types for the serial baud rate generator.
// Assumes an 8-bit register port and one system clock shared with the serial ports.
//
// Overview of operation
// - Each generator has an 8-bit compare register
// - Compare write clears that generator's internal timer
// - Mode bit 7 enables counting, else timer cleared
// - Prescale 000..011 divide 2..16, 1xx divides 32
// - Registers take byte and single-bit accesses
// - Compare zero counts 256, else value itself
// - Serial bit rate is clock/(2*j*2^k*2)
`default_nettype none

package sbg_pkg;

  localparam int SBG_UNITS = 3;
  localparam int SBG_AW = 32;
  localparam int SBG_DW = 8;

  // Register addresses, one per generator
  localparam logic [SBG_UNITS-1:0][SBG_AW-1:0] SBG_ADDR_CMP = {32'h0FFF_F0A4, 32'hFFFF_F094, 32'hFFFF_F084};
  localparam logic [SBG_UNITS-1:0][SBG_AW-1:0] SBG_ADDR_MODE = {32'h0FFF_F0A6, 32'hFFFF_F096, 32'hFFFF_F086};

  // Mode register fields
  localparam int SBG_MODE_EN_BIT = 7;
  localparam int SBG_MODE_SEL_LSB = 0;
  localparam int SBG_MODE_SEL_W = 3;

  // Reset values; compare powers up undefined, zero is picked here
  localparam logic [7:0] SBG_CMP_RST = 8'h00;
  localparam logic [7:0] SBG_MODE_RST = 8'h00;

  // Largest prescaler power (divide by 32 is 2 * 2^4)
  localparam logic [2:0] SBG_PRE_MAX_K = 3'h4;

  typedef struct packed {
    logic en;
    logic [SBG_MODE_SEL_W-1:0] sel;
  } sbg_cfg_t;

  typedef struct packed {
    logic [SBG_AW-1:0] addr;
    logic [SBG_DW-1:0] wdata;
    logic [SBG_DW-1:0] wmask;
    logic wr;
    logic rd;
  } sbg_req_t;

endpackage : sbg_pkg

`default_nettype wire

// ### verif/sbg_baud_gen_tb.sv
// Bench: register access and serial clock period of all units.
// Assumes the checker and serial model are compiled first.
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module sbg_baud_gen_tb
  import sbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  sbg_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic [2:0] baud_clk_o;
  logic [2:0] match_o;
  logic [15:0] period;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int u = 0;
  sbg_baud_gen #(.NUM_UNITS(3)) sbg_baud_gen_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
    .rdata_o(rdata_o), .baud_clk_o(baud_clk_o), .match_o(match_o));
  sbg_serial_model sbg_serial_model_i (.clk_i(clk_i), .sclk_i(baud_clk_o[u]), .period_o(period));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (++cycles == 100000)
    begin
      num_errors++;
      summarize();
    end
  function automatic int per(input logic [7:0] j, input logic [2:0] s);
    return 2 * (j == 8'h00 ? 256 : j) * (2 << (s[2] ? 4 : s));
  endfunction : per
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_i);
    req_i <= '{a, d, m, 1'b1, 1'b0};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk_i);
    req_i <= '{a, 8'h00, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask : rd
  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial
  begin
    logic [7:0] d;
    logic [7:0] j;
    int n;
    void'($urandom(32'h36a4_721f));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd(SBG_ADDR_MODE[i], 8'h00);
      d = 8'($urandom);
      wr(SBG_ADDR_CMP[i], d, 8'hff);
      rd(SBG_ADDR_CMP[i], d);
      wr(SBG_ADDR_CMP[i], ~d, 8'h01);
      rd(SBG_ADDR_CMP[i], {d[7:1], ~d[0]});
      wr(SBG_ADDR_MODE[i], 8'hff, 8'h09);
      rd(SBG_ADDR_MODE[i], 8'h01);
      rd(32'h0000_0000, 8'h00);
    end
    // Code 8 reuses select 0 with compare 0, the longest count
    for (u = 0; u < 3; u++)
      for (int s = 0; s < 9; s++)
      begin
        j = (s == 8) ? 8'h00 : 8'($urandom_range(1, 4));
        wr(SBG_ADDR_CMP[u], j, 8'hff);
        wr(SBG_ADDR_MODE[u], {5'h10, s[2:0]}, 8'hff);
        rd(SBG_ADDR_MODE[u], {5'h10, s[2:0]});
        repeat (3 * per(j, s[2:0]) + 8) @(posedge clk_i);
        `CHK(period, 16'(per(j, s[2:0])))
        // A compare write while running restarts the count: first match one half period later
        wr(SBG_ADDR_CMP[u], j, 8'hff);
        n = 0;
        #1;
        while (match_o[u] !== 1'b1 && n < 1100)
        begin
          @(posedge clk_i);
          #1;
          n++;
        end
        `CHK(n, per(j, s[2:0]) / 2)
        wr(SBG_ADDR_MODE[u], 8'h00, 8'hff);
      end
    summarize();
  end
endmodule : sbg_baud_gen_tb
`default_nettype wire

// ### verif/sbg_checker.sv
// Port assertions for the baud generators; clear and stop checks watch unit 0.
// Assumes the bind below attaches it to sbg_baud_gen.
`default_nettype none
module sbg_checker
  import sbg_pkg::*;
#(
  parameter int NUM_UNITS = 3
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire sbg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic [NUM_UNITS-1:0] baud_clk_o,
  input wire logic [NUM_UNITS-1:0] match_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic cw;
  logic mw;
  assign cw = req_i.wr && req_i.addr == SBG_ADDR_CMP[0];
  assign mw = req_i.wr && req_i.addr == SBG_ADDR_MODE[0] && req_i.wmask[7] && !req_i.wdata[7];
  rd_idle_a: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00) else $error("rdata idle");
  rd_hole_a: assert property (req_i.rd && req_i.addr == 32'h0 |=> rdata_o == 8'h00) else $error("hole");
  clk_tog_a: assert property (((baud_clk_o ^ $past(baud_clk_o)) & match_o) == match_o) else $error("tog");
  match_gap_a: assert property ((match_o & $past(match_o)) == '0) else $error("gap");
  cmp_clear_a: assert property (cw |=> !match_o[0] [*2]) else $error("clear");
  stop_clr_a: assert property (mw |=> ##1 !baud_clk_o[0]) else $error("stop");
endmodule : sbg_checker
bind sbg_baud_gen sbg_checker #(.NUM_UNITS(NUM_UNITS)) sbg_checker_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .req_i(req_i), .rdata_o(rdata_o), .baud_clk_o(baud_clk_o), .match_o(match_o));
`default_nettype wire

// ### verif/sbg_serial_model.sv
// Serial port model: measures the serial clock period in system clocks.
// Assumes that clock is synchronous to clk_i.
`default_nettype none
module sbg_serial_model
(
  input wire logic clk_i,
  input wire logic sclk_i,
  output logic [15:0] period_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  logic [15:0] cnt = 16'h0000;
  initial period_o = 16'h0000;
  // Rising to rising, so the whole period is measured and duty cycle errors go unseen
  always @(posedge clk_i)
  begin
    last <= sclk_i;
    cnt <= (sclk_i && !last) ? 16'h0001 : cnt + 16'h0001;
    if (sclk_i && !last)
      period_o <= cnt;
  end
endmodule : sbg_serial_model
`default_nettype wire
